// *** logic/cpu_flag_map.vh ***
`ifndef CPU_FLAG_MAP_VH
`define CPU_FLAG_MAP_VH
// ----------------------------------------
// Condition-code bit positions
// ----------------------------------------
`define CC_GMASK 7
`define CC_UMASK 6
`define CC_HALF 5
`define CC_USER 4
`define CC_NEG 3
`define CC_ZERO 2
`define CC_OVF 1
`define CC_CARRY 0
// ----------------------------------------
// Extended control layout and reset values
// ----------------------------------------
`define XC_ONES 8'h78
`define XC_RESET 8'hff
`define CC_RESET 8'h80
`define IP_RESET 24'h000000
// ----------------------------------------
// Operand sizes
// ----------------------------------------
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE 5'h00
`define OP_ADD 5'h01
`define OP_ADDX 5'h02
`define OP_SUB 5'h03
`define OP_SUBX 5'h04
`define OP_CMP 5'h05
`define OP_NEG 5'h06
`define OP_LOGIC 5'h07
`define OP_SHL 5'h08
`define OP_SHR 5'h09
`define OP_BLD 5'h0a
`define OP_BAND 5'h0b
`define OP_BOR 5'h0c
`define OP_BXOR 5'h0d
`define OP_BST 5'h0e
`define OP_DAA 5'h0f
`define OP_DAS 5'h10
`define OP_LDC 5'h11
`define OP_AND_CONTROL_OP 5'h12
`define OP_ORC 5'h13
`define OP_XOR_CONTROL_OP 5'h14
`define OP_LDX 5'h15
`define OP_EXC 5'h16
`endif

// *** logic/cpu_flag_core.v ***
`timescale 1ns/100ps
// Overview of operation
// - 24-bit pointer; fetch address LSB forced 0
// - Extended control register has no effect
// - Extended control bits 6..3 read as one
// - Trace and priority mask bits are inert
// - Global mask blocks all but non-maskable
// - Exception entry sets global mask
// - Bit 6 writable, optional extra mask
// - Byte half-carry from bit 3
// - Word half-carry from bit 11
// - Long half-carry from bit 27
// - Bit 4 is software user bit
// - Negative flag copies result sign
// - Zero flag set on zero result
// - Overflow flag set on overflow only
// - Carry from add, borrow, shift-out
// - Carry flag is bit accumulator
// - Bit ops index bits 0..7 of byte
// - Decimal adjust uses two BCD nibbles
// - Widths: bit, nibble, byte, word, long
// - Both bytes of data register lower half accessible
`include "cpu_flag_map.vh"
module cpu_flag_core (
  input wire ref_clk,
  input wire srst,
  input wire ip_load,
  input wire [23:0] ip_load_val,
  input wire ip_step,
  input wire exc_entry,
  input wire irq_req,
  input wire nmi_req,
  input wire aux_mask_en,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [1:0] op_size,
  input wire [31:0] opnd_a,
  input wire [31:0] opnd_b,
  input wire [2:0] bit_index,
  input wire [1:0] reg_part,
  input wire [31:0] reg_word,
  input wire [23:0] mem_addr,
  output reg [23:0] instruction_pointer,
  output reg [23:0] fetch_addr,
  output reg [7:0] condition_code,
  output wire [7:0] extended_control,
  output reg [31:0] op_result,
  output reg [7:0] part_out,
  output wire align_err,
  output wire irq_take,
  output wire nmi_take
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Sign bit of a result for the given size
  function msb_of;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: msb_of = v[7];
        `SZ_WORD: msb_of = v[15];
        default: msb_of = v[31];
      endcase
    end
  endfunction

  // Result masked to operand width
  function [31:0] trim;
    input [31:0] v;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: trim = {24'h000000, v[7:0]};
        `SZ_WORD: trim = {16'h0000, v[15:0]};
        default: trim = v;
      endcase
    end
  endfunction

  // Half-carry position: bit 3, 11 or 27 low part
  function [31:0] low_mask;
    input [1:0] sz;
    begin
      case (sz)
        `SZ_BYTE: low_mask = 32'h0000000f;
        `SZ_WORD: low_mask = 32'h00000fff;
        default: low_mask = 32'h0fffffff;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Instruction pointer
  // ----------------------------------------
  // Next pointer and stored extended control
  reg [23:0] ip_nxt;
  reg [7:0] xc_r;

  // Next pointer value
  always @* begin
    ip_nxt = instruction_pointer;
    if (ip_load)
      ip_nxt = ip_load_val;
    else if (ip_step)
      ip_nxt = instruction_pointer + 24'h000002;
  end

  // Pointer and even fetch address registers
  always @(posedge ref_clk) begin
    if (srst) begin
      instruction_pointer <= `IP_RESET;
      fetch_addr <= `IP_RESET;
    end else begin
      instruction_pointer <= ip_nxt;
      fetch_addr <= {ip_nxt[23:1], 1'b0};
    end
  end

  // ----------------------------------------
  // Extended control and interrupt gating
  // ----------------------------------------
  // Reserved bits forced to one on read
  assign extended_control = xc_r | `XC_ONES;
  // No logic reads xc_r beyond the read path
  assign nmi_take = nmi_req;
  // Maskable request gated by both mask bits
  assign irq_take = irq_req & ~nmi_req & ~condition_code[`CC_GMASK] &
    ~(aux_mask_en & condition_code[`CC_UMASK]);
  // Word and long operands need an even address
  assign align_err = op_valid & (op_size != `SZ_BYTE) & mem_addr[0];

  // ----------------------------------------
  // Datapath and flags
  // ----------------------------------------
  // Datapath working values
  reg [32:0] full;
  reg [31:0] lo;
  reg [31:0] res_nxt;
  reg [7:0] cc_nxt;
  reg [7:0] xc_nxt;
  reg hc;
  reg cy;
  reg sa;
  reg sb;
  reg sr;
  reg bsel;
  reg [7:0] adj;
  reg sub_op;

  // Result and next flags of the current operation
  always @* begin
    full = 33'h000000000;
    lo = 32'h00000000;
    res_nxt = op_result;
    cc_nxt = condition_code;
    xc_nxt = xc_r;
    hc = 1'b0;
    cy = condition_code[`CC_CARRY];
    sa = msb_of(opnd_a, op_size);
    sb = msb_of(opnd_b, op_size);
    sr = 1'b0;
    bsel = opnd_b[bit_index];
    adj = 8'h00;
    sub_op = 1'b0;
    if (op_valid) begin
      // Adder and subtractor with half-carry tap
      case (op_code)
        `OP_ADD, `OP_ADDX: begin
          lo = (opnd_a & low_mask(op_size)) + (opnd_b & low_mask(op_size));
          full = {1'b0, trim(opnd_a, op_size)} + {1'b0, trim(opnd_b, op_size)};
          if (op_code == `OP_ADDX) begin
            lo = lo + {31'h00000000, condition_code[`CC_CARRY]};
            full = full + {32'h00000000, condition_code[`CC_CARRY]};
          end
          hc = |(lo & ~low_mask(op_size));
        end
        `OP_SUB, `OP_SUBX, `OP_CMP, `OP_NEG: begin
          sub_op = 1'b1;
          if (op_code == `OP_NEG) begin
            sa = 1'b0;
            lo = 32'h00000000 - (opnd_b & low_mask(op_size));
            full = 33'h000000000 - {1'b0, trim(opnd_b, op_size)};
          end else begin
            lo = (opnd_a & low_mask(op_size)) - (opnd_b & low_mask(op_size));
            full = {1'b0, trim(opnd_a, op_size)} - {1'b0, trim(opnd_b, op_size)};
          end
          if (op_code == `OP_SUBX) begin
            lo = lo - {31'h00000000, condition_code[`CC_CARRY]};
            full = full - {32'h00000000, condition_code[`CC_CARRY]};
          end
          hc = |(lo & ~low_mask(op_size));
        end
        default: full = 33'h000000000;
      endcase
      // Result and flag write by operation class
      case (op_code)
        `OP_ADD, `OP_ADDX, `OP_SUB, `OP_SUBX, `OP_CMP, `OP_NEG: begin
          res_nxt = trim(full[31:0], op_size);
          sr = msb_of(res_nxt, op_size);
          cy = (op_size == `SZ_BYTE) ? full[8] :
            (op_size == `SZ_WORD) ? full[16] : full[32];
          cc_nxt[`CC_HALF] = hc;
          cc_nxt[`CC_NEG] = sr;
          if (op_code == `OP_ADDX || op_code == `OP_SUBX)
            cc_nxt[`CC_ZERO] = condition_code[`CC_ZERO] & (res_nxt == 32'h00000000);
          else
            cc_nxt[`CC_ZERO] = (res_nxt == 32'h00000000);
          cc_nxt[`CC_OVF] = sub_op ? ((sa ^ sb) & (sa ^ sr))
            : (~(sa ^ sb) & (sa ^ sr));
          cc_nxt[`CC_CARRY] = cy;
          if (op_code == `OP_CMP)
            res_nxt = op_result;
        end
        `OP_LOGIC: begin
          res_nxt = trim(opnd_a, op_size);
          cc_nxt[`CC_NEG] = msb_of(res_nxt, op_size);
          cc_nxt[`CC_ZERO] = (res_nxt == 32'h00000000);
          cc_nxt[`CC_OVF] = 1'b0;
        end
        `OP_SHL, `OP_SHR: begin
          if (op_code == `OP_SHL) begin
            cy = sa;
            res_nxt = trim({opnd_a[30:0], 1'b0}, op_size);
          end else begin
            cy = opnd_a[0];
            res_nxt = trim(opnd_a, op_size) >> 1;
          end
          cc_nxt[`CC_NEG] = msb_of(res_nxt, op_size);
          cc_nxt[`CC_ZERO] = (res_nxt == 32'h00000000);
          cc_nxt[`CC_OVF] = 1'b0;
          cc_nxt[`CC_CARRY] = cy;
        end
        `OP_BLD: cc_nxt[`CC_CARRY] = bsel;
        `OP_BAND: cc_nxt[`CC_CARRY] = cy & bsel;
        `OP_BOR: cc_nxt[`CC_CARRY] = cy | bsel;
        `OP_BXOR: cc_nxt[`CC_CARRY] = cy ^ bsel;
        `OP_BST: begin
          res_nxt = {24'h000000, opnd_b[7:0]};
          res_nxt[bit_index] = cy;
        end
        `OP_DAA, `OP_DAS: begin
          // Correction per nibble from half-carry and carry
          if (condition_code[`CC_HALF] || (op_code == `OP_DAA && opnd_a[3:0] > 4'h9))
            adj[3:0] = 4'h6;
          if (cy || (op_code == `OP_DAA && opnd_a[7:4] > 4'h9) ||
              (op_code == `OP_DAA && opnd_a[7:4] == 4'h9 && opnd_a[3:0] > 4'h9)) begin
            adj[7:4] = 4'h6;
            if (op_code == `OP_DAA)
              cy = 1'b1;
          end
          res_nxt[7:0] = (op_code == `OP_DAA) ? opnd_a[7:0] + adj : opnd_a[7:0] - adj;
          res_nxt[31:8] = 24'h000000;
          cc_nxt[`CC_NEG] = res_nxt[7];
          cc_nxt[`CC_ZERO] = (res_nxt[7:0] == 8'h00);
          cc_nxt[`CC_CARRY] = cy;
        end
        `OP_LDC: cc_nxt = opnd_a[7:0];
        `OP_AND_CONTROL_OP: cc_nxt = condition_code & opnd_a[7:0];
        `OP_ORC: cc_nxt = condition_code | opnd_a[7:0];
        `OP_XOR_CONTROL_OP: cc_nxt = condition_code ^ opnd_a[7:0];
        `OP_LDX: xc_nxt = opnd_a[7:0];
        `OP_EXC: cc_nxt = condition_code;
        default: res_nxt = op_result;
      endcase
    end
    // Exception entry beats any write of the global mask bit
    if (exc_entry)
      cc_nxt[`CC_GMASK] = 1'b1;
  end

  // Flag, extended control and result registers
  always @(posedge ref_clk) begin
    if (srst) begin
      condition_code <= `CC_RESET;
      xc_r <= `XC_RESET;
      op_result <= 32'h00000000;
    end else begin
      condition_code <= cc_nxt;
      xc_r <= xc_nxt;
      op_result <= res_nxt;
    end
  end

  // ----------------------------------------
  // Data register part selection
  // ----------------------------------------
  // 0 low byte, 1 high byte of lower half
  always @(posedge ref_clk) begin
    if (srst)
      part_out <= 8'h00;
    else if (reg_part[0])
      part_out <= reg_word[15:8];
    else
      part_out <= reg_word[7:0];
  end

endmodule // cpu_flag_core

// *** test/cpu_flag_chk.sv ***
`timescale 1ns/100ps
module cpu_flag_chk (
  input wire ref_clk,
  input wire srst,
  input wire ip_load,
  input wire [23:0] ip_load_val,
  input wire ip_step,
  input wire exc_entry,
  input wire irq_req,
  input wire nmi_req,
  input wire aux_mask_en,
  input wire op_valid,
  input wire [1:0] op_size,
  input wire [23:0] mem_addr,
  input wire [23:0] instruction_pointer,
  input wire [23:0] fetch_addr,
  input wire [7:0] condition_code,
  input wire [7:0] extended_control,
  input wire align_err,
  input wire irq_take,
  input wire nmi_take
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_fetch_even: assert property (fetch_addr == {instruction_pointer[23:1], 1'b0})
    else $error("fetch address not the even pointer");
  chk_ip_load: assert property (ip_load |=> instruction_pointer == $past(ip_load_val))
    else $error("pointer load missed");
  chk_ip_step: assert property (ip_step && !ip_load |=>
    instruction_pointer == $past(instruction_pointer) + 24'h000002)
    else $error("pointer step not by two");
  chk_xc_ones: assert property (extended_control[6:3] == 4'hf)
    else $error("reserved control bits not one");
  chk_exc_mask: assert property (exc_entry |=> condition_code[7] ##1 1'b1)
    else $error("exception entry left mask clear");
  chk_mask_irq: assert property (condition_code[7] |-> !irq_take)
    else $error("masked interrupt taken");
  chk_nmi_pass: assert property (nmi_req |-> nmi_take && !irq_take)
    else $error("non-maskable request not taken");
  chk_aux_mask: assert property (aux_mask_en && condition_code[6] |-> !irq_take)
    else $error("extra mask bit ignored");
  chk_irq_open: assert property (irq_req && !nmi_req && !condition_code[7] &&
    !(aux_mask_en && condition_code[6]) |-> irq_take)
    else $error("open interrupt not taken");
  chk_align_odd: assert property (align_err == (op_valid && op_size != 2'h0 && mem_addr[0]))
    else $error("alignment flag wrong");
  cov_exc: cover property (exc_entry ##1 condition_code[7]);
  cov_irq: cover property (irq_take);
  cov_align: cover property (align_err);
endmodule // cpu_flag_chk

bind cpu_flag_core cpu_flag_chk u_chk (.ref_clk, .srst, .ip_load, .ip_load_val, .ip_step,
  .exc_entry, .irq_req, .nmi_req, .aux_mask_en, .op_valid, .op_size, .mem_addr,
  .instruction_pointer, .fetch_addr, .condition_code, .extended_control, .align_err,
  .irq_take, .nmi_take);

// *** test/cpu_flag_core_tb.sv ***
`timescale 1ns/100ps
`include "cpu_flag_map.vh"
module cpu_flag_core_tb;
  typedef struct packed {
    logic [4:0] op; logic [1:0] sz; logic [31:0] a; logic [31:0] b; logic [2:0] ix;
    logic [31:0] r; logic [7:0] m; logic [7:0] e;
  } row_t;
  reg ref_clk = 0, srst = 1, ip_load = 0, ip_step = 0, exc_entry = 0, irq_req = 0;
  reg nmi_req = 0, aux_mask_en = 0, op_valid = 0;
  reg [4:0] op_code = 0;
  reg [1:0] op_size = 0, reg_part = 0;
  reg [31:0] opnd_a = 0, opnd_b = 0, reg_word = 0;
  reg [23:0] ip_load_val = 0, mem_addr = 0;
  reg [2:0] bit_index = 0;
  wire [23:0] instruction_pointer, fetch_addr;
  wire [7:0] condition_code, extended_control, part_out;
  wire [31:0] op_result;
  wire align_err, irq_take, nmi_take;
  integer miscompares = 0, compares = 0, i;
  // ----------------------------------------
  // Ordinary operations with expected flags
  // ----------------------------------------
  row_t rows [0:21] = '{
    '{`OP_ADD, `SZ_BYTE, 32'h0f, 32'h01, 3'h0, 32'h10, 8'h2f, 8'h20},
    '{`OP_ADD, `SZ_BYTE, 32'h7f, 32'h01, 3'h0, 32'h80, 8'h2f, 8'h2a},
    '{`OP_ADD, `SZ_BYTE, 32'hff, 32'h01, 3'h0, 32'h00, 8'h2f, 8'h25},
    '{`OP_ADD, `SZ_WORD, 32'h0fff, 32'h01, 3'h0, 32'h1000, 8'h2f, 8'h20},
    '{`OP_ADD, `SZ_LONG, 32'h0fffffff, 32'h01, 3'h0, 32'h10000000, 8'h2f, 8'h20},
    '{`OP_SUB, `SZ_BYTE, 32'h10, 32'h01, 3'h0, 32'h0f, 8'h2f, 8'h20},
    '{`OP_DAS, `SZ_BYTE, 32'h0f, 32'h00, 3'h0, 32'h09, 8'h00, 8'h00},
    '{`OP_SUB, `SZ_BYTE, 32'h00, 32'h01, 3'h0, 32'hff, 8'h2f, 8'h29},
    '{`OP_CMP, `SZ_WORD, 32'h00, 32'h01, 3'h0, 32'hff, 8'h2f, 8'h29},
    '{`OP_NEG, `SZ_LONG, 32'h00, 32'h01, 3'h0, 32'hffffffff, 8'h2f, 8'h29},
    '{`OP_ADD, `SZ_BYTE, 32'h09, 32'h01, 3'h0, 32'h0a, 8'h2f, 8'h00},
    '{`OP_DAA, `SZ_BYTE, 32'h0a, 32'h00, 3'h0, 32'h10, 8'h00, 8'h00},
    '{`OP_SHL, `SZ_BYTE, 32'h81, 32'h00, 3'h0, 32'h02, 8'h0d, 8'h01},
    '{`OP_SHR, `SZ_BYTE, 32'h01, 32'h00, 3'h0, 32'h00, 8'h0d, 8'h05},
    '{`OP_BAND, `SZ_BYTE, 32'h00, 32'h00, 3'h7, 32'h00, 8'h01, 8'h00},
    '{`OP_BOR, `SZ_BYTE, 32'h00, 32'h80, 3'h7, 32'h00, 8'h01, 8'h01},
    '{`OP_BXOR, `SZ_BYTE, 32'h00, 32'h80, 3'h7, 32'h00, 8'h01, 8'h00},
    '{`OP_BLD, `SZ_BYTE, 32'h00, 32'h04, 3'h2, 32'h00, 8'h01, 8'h01},
    '{`OP_BST, `SZ_BYTE, 32'h00, 32'h00, 3'h3, 32'h08, 8'h01, 8'h01},
    '{`OP_ADDX, `SZ_BYTE, 32'h0e, 32'h01, 3'h0, 32'h10, 8'h2f, 8'h20},
    '{`OP_SUBX, `SZ_BYTE, 32'h10, 32'h01, 3'h0, 32'h0f, 8'h2f, 8'h20},
    '{`OP_LOGIC, `SZ_BYTE, 32'h80, 32'h00, 3'h0, 32'h80, 8'h0f, 8'h08}};

  cpu_flag_core dut (.ref_clk(ref_clk), .srst(srst), .ip_load(ip_load),
    .ip_load_val(ip_load_val), .ip_step(ip_step), .exc_entry(exc_entry), .irq_req(irq_req),
    .nmi_req(nmi_req), .aux_mask_en(aux_mask_en), .op_valid(op_valid), .op_code(op_code),
    .op_size(op_size), .opnd_a(opnd_a), .opnd_b(opnd_b), .bit_index(bit_index),
    .reg_part(reg_part), .reg_word(reg_word), .mem_addr(mem_addr),
    .instruction_pointer(instruction_pointer), .fetch_addr(fetch_addr),
    .condition_code(condition_code), .extended_control(extended_control),
    .op_result(op_result), .part_out(part_out), .align_err(align_err),
    .irq_take(irq_take), .nmi_take(nmi_take));

  // Clock at 125 MHz
  always #4 ref_clk = ~ref_clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // One operation, issued for a single edge
  task op(input logic [4:0] c, input logic [1:0] s, input logic [31:0] a, input logic [31:0] b,
    input logic [2:0] x);
    begin
      @(negedge ref_clk);
      op_code = c; op_size = s; opnd_a = a; opnd_b = b; bit_index = x; op_valid = 1;
      @(negedge ref_clk);
      op_valid = 0;
    end
  endtask

  task test_done;
    begin
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  // Watchdog
  initial begin
    #20000;
    miscompares = miscompares + 1;
    test_done;
  end

  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    srst = 0;
    chk({8'h0, instruction_pointer}, 32'h0);
    chk({24'h0, condition_code}, 32'h80);
    chk({24'h0, extended_control}, 32'hff);
    for (i = 0; i < 22; i = i + 1) begin
      op(rows[i].op, rows[i].sz, rows[i].a, rows[i].b, rows[i].ix);
      chk(op_result, rows[i].r);
      chk({24'h0, condition_code & rows[i].m}, {24'h0, rows[i].e});
    end
    // Pointer load beats step, then step by two
    ip_load = 1; ip_step = 1; ip_load_val = 24'h123457;
    @(negedge ref_clk);
    ip_load = 0;
    chk({8'h0, fetch_addr}, 32'h123456);
    @(negedge ref_clk);
    ip_step = 0;
    chk({8'h0, instruction_pointer}, 32'h123459);
    // Control transfers and interrupt masking
    irq_req = 1;
    op(`OP_LDC, `SZ_BYTE, 32'h50, 32'h0, 3'h0);
    chk({24'h0, condition_code}, 32'h50);
    chk({31'h0, irq_take}, 32'h1);
    aux_mask_en = 1;
    #1 chk({31'h0, irq_take}, 32'h0);
    @(negedge ref_clk);
    aux_mask_en = 0;
    op(`OP_AND_CONTROL_OP, `SZ_BYTE, 32'hef, 32'h0, 3'h0);
    chk({24'h0, condition_code}, 32'h40);
    op(`OP_ORC, `SZ_BYTE, 32'h10, 32'h0, 3'h0);
    chk({24'h0, condition_code}, 32'h50);
    op(`OP_XOR_CONTROL_OP, `SZ_BYTE, 32'h50, 32'h0, 3'h0);
    chk({24'h0, condition_code}, 32'h00);
    op(`OP_LDX, `SZ_BYTE, 32'h00, 32'h0, 3'h0);
    chk({24'h0, extended_control}, 32'h78);
    chk({31'h0, irq_take}, 32'h1);
    exc_entry = 1;
    @(negedge ref_clk);
    exc_entry = 0;
    nmi_req = 1;
    chk({24'h0, condition_code}, 32'h80);
    #1 chk({30'h0, irq_take, nmi_take}, 32'h1);
    // Alignment of word operands
    @(negedge ref_clk);
    op_code = `OP_NONE; op_size = `SZ_WORD; mem_addr = 24'h000001; op_valid = 1;
    #1 chk({31'h0, align_err}, 32'h1);
    @(negedge ref_clk);
    op_size = `SZ_BYTE;
    #1 chk({31'h0, align_err}, 32'h0);
    @(negedge ref_clk);
    op_valid = 0;
    // Byte parts of a data register
    reg_word = 32'h11223344; reg_part = 2'h1;
    @(negedge ref_clk);
    chk({24'h0, part_out}, 32'h33);
    reg_part = 2'h0;
    @(negedge ref_clk);
    chk({24'h0, part_out}, 32'h44);
    // Reset in mid-run restores every register
    srst = 1;
    @(negedge ref_clk);
    srst = 0;
    chk({8'h0, instruction_pointer}, 32'h0);
    chk({8'h0, fetch_addr}, 32'h0);
    chk({24'h0, condition_code}, {24'h0, `CC_RESET});
    chk({24'h0, extended_control}, {24'h0, `XC_RESET});
    chk(op_result, 32'h0);
    chk({24'h0, part_out}, 32'h0);
    test_done;
  end
endmodule // cpu_flag_core_tb
